// ---- slow_osc_ctrl.sv ----
// Slow oscillator controller with interrupt enables on an APB slave
//
// Implementation choices: the address map and the APB interface to the registers.
module slow_osc_ctrl #(
    parameter logic [7:0] osc_div = osc_ctrl_pkg::osc_div_default
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event sources
    input  wire logic        fll_out_of_range_evt,
    input  wire logic        fll_ready_evt,
    input  wire logic        fast_osc_ready_evt,
    // Clock distribution and power state
    input  wire logic        periph_clk_req,
    input  wire logic        standby,
    output logic             slow_osc_run,
    output logic             slow_osc_tick,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    osc_ctrl_pkg::bus_req_t req;
    logic                   access;
    logic                   wr_en;
    logic                   mapped;
    logic [3:0]             irq_en_q;
    logic [3:0]             irq_flag_q;
    logic [3:0]             evt;
    osc_ctrl_pkg::osc_cfg_t cfg_q;
    osc_ctrl_pkg::osc_state_t state_q;
    logic [7:0]             cnt_q;
    logic [7:0]             div_q;
    logic                   tick;
    logic                   run_d;
    logic                   ready_flag;
    logic                   ready_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [7:0] count_sel_a_len(input logic [2:0] sel);
        return 8'h01 + (8'h01 << sel) + 8'h01; // R4
    endfunction

    // Control word to configuration fields
    function automatic osc_ctrl_pkg::osc_cfg_t unpack_cfg(input logic [31:0] w);
        osc_ctrl_pkg::osc_cfg_t c;
        c.gated_run    = w[osc_ctrl_pkg::req_gated_bit];
        c.keep_standby = w[osc_ctrl_pkg::keep_standby_bit];
        c.count_sel    = w[osc_ctrl_pkg::count_sel_lsb +: 3];
        c.enable       = w[osc_ctrl_pkg::osc_enable_bit];
        return c;
    endfunction

    assign req    = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign access = psel && penable && !pready;
    assign wr_en  = access && req.write;
    assign mapped = hit(req.addr, osc_ctrl_pkg::irq_enable_clear_off)
                 || hit(req.addr, osc_ctrl_pkg::irq_enable_set_off)
                 || hit(req.addr, osc_ctrl_pkg::irq_flag_off)
                 || hit(req.addr, osc_ctrl_pkg::slow_osc_control_off)
                 || hit(req.addr, osc_ctrl_pkg::clock_source_status_off);

    // One wait state per access
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access && !mapped;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt enables and flags
    // ------------------------------------------------------------------
    assign evt = {ready_flag && !ready_q, fll_out_of_range_evt, fll_ready_evt,
                  fast_osc_ready_evt};

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_en_q <= 4'h0;
        end else if (wr_en && hit(req.addr, osc_ctrl_pkg::irq_enable_clear_off)) begin
            irq_en_q <= irq_en_q & ~req.wdata[osc_ctrl_pkg::fast_osc_ready_bit +: 4]; // R1 R2
        end else if (wr_en && hit(req.addr, osc_ctrl_pkg::irq_enable_set_off)) begin
            irq_en_q <= irq_en_q | req.wdata[osc_ctrl_pkg::fast_osc_ready_bit +: 4];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_flag_q <= 4'h0;
        end else if (wr_en && hit(req.addr, osc_ctrl_pkg::irq_flag_off)) begin
            irq_flag_q <= (irq_flag_q & ~req.wdata[osc_ctrl_pkg::fast_osc_ready_bit +: 4]) | evt;
        end else begin
            irq_flag_q <= irq_flag_q | evt;
        end
    end

    // Not gated by standby so it can wake the device
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_en_q & irq_flag_q); // R3 R10
        end
    end

    // ------------------------------------------------------------------
    // Oscillator configuration
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q <= unpack_cfg(osc_ctrl_pkg::slow_osc_control_rst);
        end else if (wr_en && hit(req.addr, osc_ctrl_pkg::slow_osc_control_off)) begin
            cfg_q <= unpack_cfg(req.wdata);
        end
    end

    // Run decision
    always_comb begin
        run_d = cfg_q.enable && (!cfg_q.gated_run || periph_clk_req); // R6 R7
        if (standby && !cfg_q.keep_standby) begin
            run_d = 1'b0; // R8
        end // R9
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            slow_osc_run <= 1'b0;
        end else begin
            slow_osc_run <= run_d;
        end
    end

    // Oscillator cycle enable from divider
    assign tick = slow_osc_run && (div_q == 8'h00);

    always_ff @(posedge mclk) begin
        if (rst || !slow_osc_run) begin
            div_q <= 8'h00;
        end else if (div_q == osc_div - 8'h01) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            slow_osc_tick <= 1'b0;
        end else begin
            slow_osc_tick <= tick;
        end
    end

    // ------------------------------------------------------------------
    // Start-up and synchronisation
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst || !run_d) begin
            state_q <= osc_ctrl_pkg::osc_stopped; // R12
            cnt_q   <= 8'h00;
        end else begin
            case (state_q)
                osc_ctrl_pkg::osc_stopped: begin
                    state_q <= osc_ctrl_pkg::osc_starting;
                    cnt_q   <= count_sel_a_len(cfg_q.count_sel); // R4
                end
                osc_ctrl_pkg::osc_starting: begin
                    if (tick) begin
                        if (cnt_q == 8'h01) begin
                            state_q <= osc_ctrl_pkg::osc_syncing;
                            cnt_q   <= osc_ctrl_pkg::sync_delay_cycles; // R5
                        end else begin
                            cnt_q <= cnt_q - 8'h01; // R4
                        end
                    end
                end
                osc_ctrl_pkg::osc_syncing: begin
                    if (tick) begin
                        if (cnt_q == 8'h01) begin
                            state_q <= osc_ctrl_pkg::osc_ready;
                        end
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                osc_ctrl_pkg::osc_ready: begin
                    state_q <= osc_ctrl_pkg::osc_ready;
                end
                default: begin
                    state_q <= osc_ctrl_pkg::osc_stopped;
                end
            endcase
        end
    end

    assign ready_flag = (state_q == osc_ctrl_pkg::osc_ready);

    always_ff @(posedge mclk) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_flag; // R12
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (access && !req.write) begin
            prdata <= 32'h0000_0000;
            if (hit(req.addr, osc_ctrl_pkg::irq_enable_clear_off)
                || hit(req.addr, osc_ctrl_pkg::irq_enable_set_off)) begin
                prdata[osc_ctrl_pkg::fast_osc_ready_bit +: 4] <= irq_en_q; // R11
            end else if (hit(req.addr, osc_ctrl_pkg::irq_flag_off)) begin
                prdata[osc_ctrl_pkg::fast_osc_ready_bit +: 4] <= irq_flag_q;
            end else if (hit(req.addr, osc_ctrl_pkg::slow_osc_control_off)) begin
                prdata[osc_ctrl_pkg::req_gated_bit]       <= cfg_q.gated_run;
                prdata[osc_ctrl_pkg::keep_standby_bit]    <= cfg_q.keep_standby;
                prdata[osc_ctrl_pkg::count_sel_lsb +: 3]  <= cfg_q.count_sel;
                prdata[osc_ctrl_pkg::osc_enable_bit]      <= cfg_q.enable;
            end else if (hit(req.addr, osc_ctrl_pkg::clock_source_status_off)) begin
                prdata[osc_ctrl_pkg::ready_status_bit]    <= ready_q;
            end
        end
    end

endmodule // slow_osc_ctrl

// ---- osc_ctrl_pkg.sv ----
// Constants, register map and types for the slow oscillator controller
// Notes on behaviour
// [R1] Writing zero to an interrupt enable clear bit leaves that enable as it was.
// [R2] Writing one to an interrupt enable clear bit clears that enable.
// [R3] An interrupt request is raised while a source has both its enable and its flag set.
// [R4] The three-bit start-up code selects 3, 4, 6, 10, 18, 34, 66 or 130 oscillator cycles.
// [R5] The ready flag sets only after the start-up count plus two more oscillator cycles.
// [R6] With request gated run set, the oscillator runs only while a peripheral requests it.
// [R7] With request gated run clear, an enabled oscillator runs regardless of requests.
// [R8] In standby with keep running in standby clear, the oscillator is stopped.
// [R9] In standby with keep running in standby set, the oscillator keeps its normal gating.
// [R10] The interrupt output stays live in sleep so that it can wake the device.
// [R11] Reading the interrupt enable clear register returns the current enables.
// [R12] The ready flag drops whenever the oscillator stops and start-up restarts on the next run.
package osc_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] irq_enable_clear_off = 8'h00;
    localparam logic [7:0] irq_enable_set_off   = 8'h04;
    localparam logic [7:0] irq_flag_off         = 8'h08;
    localparam logic [7:0] slow_osc_control_off = 8'h0c;
    localparam logic [7:0] clock_source_status_off = 8'h10;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int fast_osc_ready_bit   = 3;
    localparam int fll_ready_bit        = 4;
    localparam int fll_out_of_range_bit = 5;
    localparam int slow_osc_ready_bit   = 6;
    localparam int irq_src_num          = 4;
    localparam int osc_enable_bit       = 1;
    localparam int keep_standby_bit     = 6;
    localparam int req_gated_bit        = 7;
    localparam int count_sel_lsb        = 8;
    localparam int ready_status_bit     = 1;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [31:0] slow_osc_control_rst = 32'h0000_0000;
    localparam logic [7:0]  sync_delay_cycles    = 8'h02;
    localparam logic [7:0]  osc_div_default      = 8'h04;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic       gated_run;
        logic       keep_standby;
        logic [2:0] count_sel;
        logic       enable;
    } osc_cfg_t;

    typedef enum logic [1:0] {
        osc_stopped,
        osc_starting,
        osc_syncing,
        osc_ready
    } osc_state_t;

endpackage

// ---- osc_ctrl_asserts.sv ----
// Port checker for the slow oscillator controller
module osc_ctrl_asserts #(
    parameter logic [7:0] osc_div = osc_ctrl_pkg::osc_div_default
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Oscillator and interrupt
    input wire logic        periph_clk_req,
    input wire logic        standby,
    input wire logic        slow_osc_run,
    input wire logic        slow_osc_tick,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctl_q;
    // Shadow of the control register
    always_ff @(posedge mclk) begin
        if (rst) ctl_q <= '0;
        else if (psel && penable && pwrite && !pready &&
                 paddr == osc_ctrl_pkg::slow_osc_control_off) ctl_q <= pwdata;
    end
    wire en    = ctl_q[osc_ctrl_pkg::osc_enable_bit];
    wire gated = ctl_q[osc_ctrl_pkg::req_gated_bit];
    wire keep  = ctl_q[osc_ctrl_pkg::keep_standby_bit];
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence access_s;
        psel && penable && !pready;
    endsequence
    sequence clr_all_s;
        access_s ##0 (pwrite && paddr == 8'h00 && pwdata[6:3] == 4'hf);
    endsequence
    chk_ready_answer: assert property (access_s |=> pready)
        else $error("no answer after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_irq_clear: assert property (clr_all_s |-> ##2 !irq)
        else $error("irq stays after enables cleared");
    chk_gated_idle: assert property ((en && gated && !periph_clk_req && !standby)[*2]
        |-> !slow_osc_run) else $error("runs without request");
    chk_free_run: assert property ((en && !gated && !standby)[*2] |-> slow_osc_run)
        else $error("stopped though free running");
    chk_standby_stop: assert property ((standby && !keep)[*2] |-> !slow_osc_run)
        else $error("runs in standby");
    chk_standby_keep: assert property ((standby && keep && en && !gated)[*2]
        |-> slow_osc_run) else $error("stopped in standby with keep");
    chk_tick_pulse: assert property (slow_osc_tick |=> !slow_osc_tick)
        else $error("tick longer than one cycle");
endmodule // osc_ctrl_asserts

bind slow_osc_ctrl osc_ctrl_asserts #(.osc_div(osc_div)) u_chk (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .periph_clk_req(periph_clk_req), .standby(standby), .slow_osc_run(slow_osc_run),
    .slow_osc_tick(slow_osc_tick), .irq(irq));

// ---- periph_req_model.sv ----
// Peripheral side model that requests the slow oscillator
module periph_req_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Demand from the bench
    input  wire logic want,
    input  wire logic slow,
    // Request to the controller
    output logic      periph_clk_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_q;
    // Slow peripherals raise their request some cycles late
    always_ff @(posedge mclk) begin
        if (rst || !want) begin
            wait_q         <= '0;
            periph_clk_req <= 1'b0;
        end else if (!slow || wait_q == 4'h7) begin
            periph_clk_req <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule // periph_req_model

// ---- testbench.sv ----
// Self-checking bench for the slow oscillator controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, standby = 0;
    logic want = 0, slow = 0, pready, pslverr, req, run, tick, irq, rerr;
    logic [7:0]  paddr = '0;
    logic [2:0]  evts = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    int mismatches = 0, num_checks = 0;
    int lens[8] = '{3, 4, 6, 10, 18, 34, 66, 130};
    always #12.5 mclk = ~mclk;
    slow_osc_ctrl #(.osc_div(8'h08)) i_dut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fll_out_of_range_evt(evts[2]), .fll_ready_evt(evts[1]),
        .fast_osc_ready_evt(evts[0]), .periph_clk_req(req), .standby(standby),
        .slow_osc_run(run), .slow_osc_tick(tick), .irq(irq));
    periph_req_model i_periph (.mclk(mclk), .rst(rst), .want(want), .slow(slow),
        .periph_clk_req(req));
    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // ------------------------------------------------------------------
    // APB transfer, entered just after a rising edge
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) chk(32'h0, 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0; penable <= 0;
        @(posedge mclk);
    endtask
    task automatic pulse(input logic [2:0] m);
        evts <= m;
        @(posedge mclk);
        evts <= '0;
        cyc(3);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_enables();
        apb(0, 8'h0c, 0); chk(rdat, 32'h0);
        apb(1, 8'h04, 32'h38); apb(0, 8'h00, 0); chk(rdat, 32'h38);
        apb(1, 8'h00, 32'h0); apb(0, 8'h00, 0); chk(rdat, 32'h38);
        apb(1, 8'h00, 32'h10); apb(0, 8'h00, 0); chk(rdat, 32'h28);
        apb(0, 8'h20, 0); chk({rdat[31:1], rerr}, 32'h1);
    endtask
    task automatic sc_irq();
        pulse(3'b001); chk(32'(irq), 32'h1);
        apb(1, 8'h00, 32'h08); cyc(2); chk(32'(irq), 32'h0);
        standby <= 1;
        pulse(3'b100); chk(32'(irq), 32'h1);
        standby <= 0;
        apb(1, 8'h08, 32'h78); cyc(2); chk(32'(irq), 32'h0);
        pulse(3'b010); chk(32'(irq), 32'h0);
        apb(1, 8'h04, 32'h10); cyc(2); chk(32'(irq), 32'h1);
        apb(1, 8'h00, 32'h78); apb(1, 8'h08, 32'h78);
    endtask
    task automatic sc_count_sel_a();
        int n, k;
        apb(1, 8'h04, 32'h40);
        for (int s = 0; s < 8; s++) begin
            apb(1, 8'h08, 32'h40);
            apb(1, 8'h0c, {21'h0, 3'(s), 8'h02});
            n = 0;
            k = 0;
            while (irq !== 1'b1 && k < 3000) begin
                @(posedge mclk);
                if (tick === 1'b1) n++;
                k++;
            end
            chk(32'(n), 32'(lens[s] + 2));
            apb(0, 8'h10, 0); chk(rdat, 32'h2);
            apb(1, 8'h0c, 0); apb(0, 8'h10, 0); chk(rdat, 32'h0);
        end
        apb(1, 8'h00, 32'h40); apb(1, 8'h08, 32'h40);
    endtask
    task automatic sc_gating();
        apb(1, 8'h0c, 32'hffff_ffff); apb(0, 8'h0c, 0); chk(rdat, 32'h7c2);
        apb(1, 8'h0c, 32'h82); cyc(3); chk(32'(run), 32'h0);
        slow <= 1; want <= 1; cyc(12); chk(32'(run), 32'h1);
        want <= 0; cyc(3); chk(32'(run), 32'h0);
        apb(0, 8'h10, 0); chk(rdat, 32'h0);
        slow <= 0; want <= 1; standby <= 1; cyc(3); chk(32'(run), 32'h0);
        apb(1, 8'h0c, 32'hc2); cyc(3); chk(32'(run), 32'h1);
        want <= 0; cyc(3); chk(32'(run), 32'h0);
        apb(1, 8'h0c, 32'h42); cyc(3); chk(32'(run), 32'h1);
        standby <= 0; cyc(3); chk(32'(run), 32'h1);
        apb(1, 8'h0c, 0);
    endtask
    initial begin
        cyc(2);
        rst <= 0;
        @(posedge mclk);
        sc_enables();
        sc_irq();
        sc_count_sel_a();
        sc_gating();
        complete_run();
    end
    initial begin
        #1250000;
        mismatches++;
        complete_run();
    end
endmodule // testbench
